// ==== shared/dbai_defs.svh ====
/*
 Constants of the dual base alarm indicator: register offsets, field positions,
 lamp codes, reset values and timing counts. Assumes inclusion by bare name.
*/
`ifndef DBAI_DEFS_SVH
`define DBAI_DEFS_SVH

`define DBAI_NUM_BASES        2
`define DBAI_ALARMS_PER_BASE  5
`define DBAI_NUM_LEDS         10

`define DBAI_LAMP_OFF         2'h0
`define DBAI_LAMP_GREEN       2'h1
`define DBAI_LAMP_RED         2'h2
`define DBAI_LAMP_AMBER       2'h3

`define DBAI_REG_LAMPS        4'h0
`define DBAI_REG_INPUTS       4'h4
`define DBAI_REG_CTRL         4'h8
`define DBAI_REG_CLEAR        4'hC

`define DBAI_IN_FRONT_BIT     10
`define DBAI_IN_VALID_LSB     11
`define DBAI_CTRL_RESET       2'h3
`define DBAI_CLEAR_BIT        0

`define DBAI_CLK_MHZ          125
`define DBAI_DEBOUNCE_MS      10
`define DBAI_DEBOUNCE_CYCLES  (`DBAI_DEBOUNCE_MS * `DBAI_CLK_MHZ * 1000)

`endif

// ==== shared/dbai_pkg.sv ====
/*
 Types of the dual base alarm indicator: lamp states and the per-base alarm
 flag bundle. Assumes nothing of its surroundings.
*/
package dbai_pkg;

	typedef enum logic [1:0] {
		DBAI_OFF,
		DBAI_GREEN,
		DBAI_RED,
		DBAI_AMBER
	} dbai_ind_e;

	typedef struct packed {
		logic supply_alarm;
		logic transmit_power_alarm;
		logic receive_data_alarm;
		logic receive_signal_alarm;
		logic frequency_alarm;
	} dbai_base_alarm_s;

	typedef logic [1:0] dbai_lamp_t;

endpackage

// ==== src/dbai_sync.sv ====
/*
 Two flip-flop synchroniser for a vector of pin levels.
 Assumes the inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/1ps
module dbai_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk_in,
	input  wire logic         nrst_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ==== src/dbai_indicator.sv ====
/*
 One four-state alarm lamp. Assumes alarm, active and clear are synchronous
 to mclk_in; clear is a one-cycle pulse.
*/
`timescale 1ns/1ps
`include "dbai_defs.svh"
module dbai_indicator (
	input  wire logic              mclk_in,
	input  wire logic              nrst_in,
	input  wire logic              active_in,
	input  wire logic              alarm_in,
	input  wire logic              clear_in,
	output dbai_pkg::dbai_lamp_t   lamp_out
);

	dbai_pkg::dbai_ind_e state_q;

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= dbai_pkg::DBAI_OFF;
		end else if (!active_in) begin
			state_q <= dbai_pkg::DBAI_OFF;
		end else if (alarm_in) begin
			// Set wins over a clear in the same cycle
			state_q <= dbai_pkg::DBAI_RED;
		end else begin
			unique case (state_q)
				dbai_pkg::DBAI_OFF:   state_q <= dbai_pkg::DBAI_GREEN;
				dbai_pkg::DBAI_GREEN: state_q <= dbai_pkg::DBAI_GREEN;
				dbai_pkg::DBAI_RED: begin
					state_q <= clear_in ? dbai_pkg::DBAI_GREEN : dbai_pkg::DBAI_AMBER;
				end
				dbai_pkg::DBAI_AMBER: begin
					state_q <= clear_in ? dbai_pkg::DBAI_GREEN : dbai_pkg::DBAI_AMBER;
				end
			endcase
		end
	end

	always_comb begin
		lamp_out = `DBAI_LAMP_OFF;
		unique case (state_q)
			dbai_pkg::DBAI_OFF:   lamp_out = `DBAI_LAMP_OFF;
			dbai_pkg::DBAI_GREEN: lamp_out = `DBAI_LAMP_GREEN;
			dbai_pkg::DBAI_RED:   lamp_out = `DBAI_LAMP_RED;
			dbai_pkg::DBAI_AMBER: lamp_out = `DBAI_LAMP_AMBER;
		endcase
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);

	chk_unknown_is_off: assert property (!active_in |=> state_q == dbai_pkg::DBAI_OFF)
		else $error("Lamp not off while base unknown");
	chk_active_goes_red: assert property (active_in && alarm_in |=> lamp_out == `DBAI_LAMP_RED)
		else $error("Active alarm not shown red");
	chk_recover_amber: assert property (
		state_q == dbai_pkg::DBAI_RED && active_in && !alarm_in && !clear_in
		|=> state_q == dbai_pkg::DBAI_AMBER ##1 (state_q == dbai_pkg::DBAI_AMBER
		|| $past(alarm_in) || $past(clear_in) || !$past(active_in)))
		else $error("Cleared alarm not latched amber");
	chk_clear_green: assert property (
		clear_in && active_in && !alarm_in
		&& (state_q == dbai_pkg::DBAI_RED || state_q == dbai_pkg::DBAI_AMBER)
		|=> state_q == dbai_pkg::DBAI_GREEN)
		else $error("Clear did not give green");

endmodule

// ==== src/dbai_top.sv ====
/*
 Front-panel alarm lamps of a two-base changeover controller, with a
 debounced reset switch, front/rear service port priority and an Avalon-MM
 slave with waitrequest. Assumes all pins are asynchronous levels and the
 bus master is on mclk_in.
*/
// What this block does
// - Ten lamps, five alarms per base
// - Lamp shows off, green, red or amber
// - Switch press acts on all lamps at once
// - Press turns amber and red lamps whose alarm has gone green
// - Front port connected disables rear port
`timescale 1ns/1ps
`include "dbai_defs.svh"
module dbai_top #(
	parameter int DEBOUNCE_CYCLES = `DBAI_DEBOUNCE_CYCLES
) (
	input  wire logic                       mclk_in,
	input  wire logic                       nrst_in,
	input  wire dbai_pkg::dbai_base_alarm_s base1_alarm_in,
	input  wire dbai_pkg::dbai_base_alarm_s base2_alarm_in,
	input  wire logic [1:0]                 report_valid_in,
	input  wire logic                       reset_switch_in,
	input  wire logic                       front_port_present_in,
	output logic [19:0]                     lamp_out,
	output logic                            rear_port_enable_out,
	input  wire logic [3:0]                 avs_address_in,
	input  wire logic                       avs_read_in,
	input  wire logic                       avs_write_in,
	input  wire logic [31:0]                avs_writedata_in,
	input  wire logic [3:0]                 avs_byteenable_in,
	output logic [31:0]                     avs_readdata_out,
	output logic                            avs_waitrequest_out
);

	localparam int NPIN = `DBAI_NUM_LEDS + 4;

	logic [NPIN-1:0]                 pin_raw;
	logic [NPIN-1:0]                 pin_sync;
	logic [`DBAI_NUM_LEDS-1:0]       alarm_s;
	logic [1:0]                      valid_s;
	logic                            switch_s;
	logic                            front_s;
	logic [1:0]                      base_enable_q;
	logic                            soft_clear_q;
	logic                            switch_stable_q;
	logic                            switch_prev_q;
	logic [20:0]                     bounce_cnt_q;
	logic                            press;
	logic                            clear_all;
	logic                            ack_q;
	logic                            bus_req;
	logic [31:0]                     read_mux;
	dbai_pkg::dbai_lamp_t            lamp_w [`DBAI_NUM_LEDS];
	logic [19:0]                     lamp_flat;

	assign pin_raw = {front_port_present_in, reset_switch_in, report_valid_in,
		base2_alarm_in, base1_alarm_in};

	dbai_sync #(
		.W(NPIN)
	) u_pin_sync (
		.mclk_in  (mclk_in),
		.nrst_in  (nrst_in),
		.async_in (pin_raw),
		.sync_out (pin_sync)
	);

	assign alarm_s  = pin_sync[`DBAI_NUM_LEDS-1:0];
	assign valid_s  = pin_sync[`DBAI_NUM_LEDS+1:`DBAI_NUM_LEDS];
	assign switch_s = pin_sync[`DBAI_NUM_LEDS+2];
	assign front_s  = pin_sync[`DBAI_NUM_LEDS+3];

	// Contact bounce would otherwise clear lamps twice; harmless but noisy
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			switch_stable_q <= 1'b0;
			bounce_cnt_q    <= '0;
		end else if (switch_s == switch_stable_q) begin
			bounce_cnt_q <= '0;
		end else if (bounce_cnt_q >= 21'(DEBOUNCE_CYCLES - 1)) begin
			switch_stable_q <= switch_s;
			bounce_cnt_q    <= '0;
		end else begin
			bounce_cnt_q <= bounce_cnt_q + 21'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			switch_prev_q <= 1'b0;
		end else begin
			switch_prev_q <= switch_stable_q;
		end
	end

	assign press     = switch_stable_q && !switch_prev_q;
	// One pulse reaches every lamp of both bases in the same cycle
	assign clear_all = press || soft_clear_q;

	genvar gi;
	generate
		for (gi = 0; gi < `DBAI_NUM_LEDS; gi++) begin : g_lamp
			dbai_indicator u_ind (
				.mclk_in   (mclk_in),
				.nrst_in   (nrst_in),
				.active_in (valid_s[gi / `DBAI_ALARMS_PER_BASE]
					&& base_enable_q[gi / `DBAI_ALARMS_PER_BASE]),
				.alarm_in  (alarm_s[gi]),
				.clear_in  (clear_all),
				.lamp_out  (lamp_w[gi])
			);
			assign lamp_flat[2*gi+1:2*gi] = lamp_w[gi];
		end
	endgenerate

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lamp_out <= '0;
		end else begin
			lamp_out <= lamp_flat;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rear_port_enable_out <= 1'b1;
		end else begin
			rear_port_enable_out <= !front_s;
		end
	end

	// Bus slave: one wait cycle, answer on the second edge of the request
	assign bus_req = avs_read_in || avs_write_in;

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ack_q               <= 1'b0;
			avs_waitrequest_out <= 1'b1;
		end else begin
			ack_q               <= bus_req && !ack_q;
			avs_waitrequest_out <= !(bus_req && !ack_q);
		end
	end

	always_comb begin
		read_mux = 32'h0;
		unique case (avs_address_in)
			`DBAI_REG_LAMPS:  read_mux[19:0] = lamp_flat;
			`DBAI_REG_INPUTS: begin
				read_mux[`DBAI_NUM_LEDS-1:0]                  = alarm_s;
				read_mux[`DBAI_IN_FRONT_BIT]                  = front_s;
				read_mux[`DBAI_IN_VALID_LSB+1:`DBAI_IN_VALID_LSB] = valid_s;
			end
			`DBAI_REG_CTRL:   read_mux[1:0] = base_enable_q;
			default:          read_mux = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			avs_readdata_out <= 32'h0;
		end else if (avs_read_in && !ack_q) begin
			avs_readdata_out <= read_mux;
		end
	end

	// Writes land on the edge where waitrequest is seen low
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			base_enable_q <= `DBAI_CTRL_RESET;
		end else if (avs_write_in && ack_q && avs_address_in == `DBAI_REG_CTRL
				&& avs_byteenable_in[0]) begin
			base_enable_q <= avs_writedata_in[1:0];
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			soft_clear_q <= 1'b0;
		end else begin
			soft_clear_q <= avs_write_in && ack_q && avs_address_in == `DBAI_REG_CLEAR
				&& avs_byteenable_in[0] && avs_writedata_in[`DBAI_CLEAR_BIT];
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);

	chk_rear_port_off: assert property (front_s |=> !rear_port_enable_out)
		else $error("Rear port enabled with front port connected");
	chk_rear_port_back: assert property (!front_s |=> rear_port_enable_out)
		else $error("Rear port not restored");
	chk_lamp_output: assert property (##1 lamp_out == $past(lamp_flat))
		else $error("Lamp output does not follow lamp states");
	chk_press_all_lamps: assert property (
		clear_all && alarm_s == '0 && valid_s == 2'h3 && base_enable_q == 2'h3
		|=> lamp_flat == {`DBAI_NUM_LEDS{`DBAI_LAMP_GREEN}})
		else $error("Press did not reach every lamp");
	chk_wait_one_cycle: assert property (
		bus_req && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
		else $error("Waitrequest not one cycle");
	chk_read_data: assert property (
		avs_read_in && avs_waitrequest_out && avs_address_in == `DBAI_REG_CTRL
		|=> avs_readdata_out[1:0] == $past(base_enable_q))
		else $error("Control readback wrong");

	// Unknown or masked base goes dark two edges after the synced level
	chk_base1_dark: assert property (
		!(valid_s[0] && base_enable_q[0]) |-> ##2 lamp_out[9:0] == 10'h000)
		else $error("Base 1 lamps not off while unknown");
	chk_base2_dark: assert property (
		!(valid_s[1] && base_enable_q[1]) |-> ##2 lamp_out[19:10] == 10'h000)
		else $error("Base 2 lamps not off while unknown");
	chk_idle_wait: assert property (!bus_req |=> avs_waitrequest_out)
		else $error("Waitrequest low without a request");
	chk_ctrl_write: assert property (
		avs_write_in && !avs_waitrequest_out && avs_address_in == `DBAI_REG_CTRL
		&& avs_byteenable_in[0] |=> base_enable_q == $past(avs_writedata_in[1:0]))
		else $error("Control write did not land");
	chk_readdata_hold: assert property (!avs_read_in |=> $stable(avs_readdata_out))
		else $error("Read data changed without a read");
	// Counter wraps back before it can overflow its width
	chk_bounce_bound: assert property (bounce_cnt_q < 21'(DEBOUNCE_CYCLES))
		else $error("Debounce counter out of range");

	// Per-lamp checks: synced input to lamp_out takes two edges
	generate
		for (gi = 0; gi < `DBAI_NUM_LEDS; gi++) begin : g_chk
			chk_lamp_red: assert property (@(posedge mclk_in) disable iff (!nrst_in)
				alarm_s[gi] && valid_s[gi / `DBAI_ALARMS_PER_BASE]
				&& base_enable_q[gi / `DBAI_ALARMS_PER_BASE]
				|-> ##2 lamp_out[2*gi+1:2*gi] == `DBAI_LAMP_RED)
				else $error("Alarm lamp not red");
			chk_lamp_amber: assert property (@(posedge mclk_in) disable iff (!nrst_in)
				lamp_flat[2*gi+1:2*gi] == `DBAI_LAMP_RED && !alarm_s[gi] && !clear_all
				&& valid_s[gi / `DBAI_ALARMS_PER_BASE]
				&& base_enable_q[gi / `DBAI_ALARMS_PER_BASE]
				|-> ##2 lamp_out[2*gi+1:2*gi] == `DBAI_LAMP_AMBER)
				else $error("Recovered lamp not amber");
			chk_lamp_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
				clear_all && !alarm_s[gi] && valid_s[gi / `DBAI_ALARMS_PER_BASE]
				&& base_enable_q[gi / `DBAI_ALARMS_PER_BASE]
				|-> ##2 lamp_out[2*gi+1:2*gi] == `DBAI_LAMP_GREEN)
				else $error("Cleared lamp not green");
		end
	endgenerate

	cov_press_clears: cover property (press ##1 lamp_flat[1:0] == `DBAI_LAMP_GREEN);
	cov_amber_seen: cover property (lamp_flat[1:0] == `DBAI_LAMP_AMBER);
	cov_front_takeover: cover property ($fell(rear_port_enable_out));
	cov_soft_clear: cover property (soft_clear_q);
	cov_base_masked: cover property (valid_s == 2'h3 && base_enable_q != 2'h3);

endmodule

// ==== verif/dbai_station_model.sv ====
/*
 Model of the far side: two base stations' status reports, the reset
 switch and the front service port. Assumes the bench calls drive().
*/
`timescale 1ns/1ps
module dbai_station_model (
	input  wire logic                  mclk_in,
	output dbai_pkg::dbai_base_alarm_s base1_alarm_out,
	output dbai_pkg::dbai_base_alarm_s base2_alarm_out,
	output logic [1:0]                 report_valid_out,
	output logic                       reset_switch_out,
	output logic                       front_port_present_out
);
	initial begin
		base1_alarm_out = 5'h00;
		base2_alarm_out = 5'h00;
		report_valid_out = 2'h3;
		reset_switch_out = 1'b0;
		front_port_present_out = 1'b0;
	end
	// Levels change just after an edge; they stay until the next call
	task automatic drive(input logic [4:0] b1, input logic [4:0] b2, input logic [1:0] v,
		input logic sw, input logic fp);
		@(posedge mclk_in);
		base1_alarm_out <= b1;
		base2_alarm_out <= b2;
		report_valid_out <= v;
		reset_switch_out <= sw;
		front_port_present_out <= fp;
	endtask
endmodule

// ==== verif/tb.sv ====
/*
 Self-checking bench of the alarm lamp block. Assumes the station model
 drives the pins and the bench is the only Avalon-MM master.
*/
`timescale 1ns/1ps
`include "dbai_defs.svh"
module tb;
	localparam logic [1:0] G = `DBAI_LAMP_GREEN;
	localparam logic [1:0] R = `DBAI_LAMP_RED;
	localparam logic [1:0] A = `DBAI_LAMP_AMBER;
	localparam logic [1:0] O = `DBAI_LAMP_OFF;
	logic                       mclk_in;
	logic                       nrst_in = 1'b0;
	dbai_pkg::dbai_base_alarm_s b1, b2;
	logic [1:0]                 rv;
	logic                       sw, fp, rear, wreq;
	logic [19:0]                lamp_out;
	logic [3:0]                 adr = 4'h0;
	logic [3:0]                 be = 4'h0;
	logic                       rd = 1'b0;
	logic                       wr = 1'b0;
	logic [31:0]                wd = 32'h0;
	logic [31:0]                rdata;
	int                         fails = 0;
	int                         n_compared = 0;
	int                         cyc = 0;
	// Short debounce keeps the run brief
	dbai_top #(.DEBOUNCE_CYCLES(4)) u_dbai_top (.mclk_in(mclk_in), .nrst_in(nrst_in),
		.base1_alarm_in(b1), .base2_alarm_in(b2), .report_valid_in(rv),
		.reset_switch_in(sw), .front_port_present_in(fp), .lamp_out(lamp_out),
		.rear_port_enable_out(rear), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq));
	dbai_station_model u_dbai_station_model (.mclk_in(mclk_in), .base1_alarm_out(b1),
		.base2_alarm_out(b2), .report_valid_out(rv), .reset_switch_out(sw),
		.front_port_present_out(fp));
	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			final_report();
		end
	end
	task automatic final_report;
		$display("compared %0d, fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask
	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] e,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk_in);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		be <= e;
		// Only the cycle ceiling ends a wait that never comes
		do begin
			@(posedge mclk_in);
		end while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	function automatic logic [31:0] all(input logic [1:0] c);
		return {12'h000, {10{c}}};
	endfunction
	task automatic lamps_are(input logic [31:0] e);
		logic [31:0] q;
		chk_word({12'h000, lamp_out}, e);
		bus(1'b0, `DBAI_REG_LAMPS, 4'hF, 32'h0, q);
		chk_word(q, e);
	endtask
	task automatic settle;
		repeat (6) @(posedge mclk_in);
	endtask
	task automatic t_reset;
		logic [31:0] q;
		settle();
		lamps_are(all(G));
		bus(1'b0, `DBAI_REG_CTRL, 4'hF, 32'h0, q);
		chk_word(q, 32'h3);
		bus(1'b0, 4'h2, 4'hF, 32'h0, q);
		chk_word(q, 32'h0);
	endtask
	task automatic t_alarm;
		logic [31:0] e;
		u_dbai_station_model.drive(5'h02, 5'h10, 2'h3, 1'b0, 1'b0);
		settle();
		e = all(G);
		e[3:2] = R;
		e[19:18] = R;
		lamps_are(e);
		u_dbai_station_model.drive(5'h00, 5'h00, 2'h3, 1'b0, 1'b0);
		settle();
		e[3:2] = A;
		e[19:18] = A;
		lamps_are(e);
		u_dbai_station_model.drive(5'h02, 5'h00, 2'h3, 1'b0, 1'b0);
		settle();
		e[3:2] = R;
		lamps_are(e);
	endtask
	task automatic t_clear;
		logic [31:0] q, e;
		e = all(G);
		e[3:2] = R;
		e[19:18] = A;
		bus(1'b1, `DBAI_REG_CLEAR, 4'hE, 32'h1, q);
		settle();
		lamps_are(e);
		bus(1'b1, `DBAI_REG_CLEAR, 4'hF, 32'h1, q);
		settle();
		e[19:18] = G;
		lamps_are(e);
		u_dbai_station_model.drive(5'h00, 5'h00, 2'h3, 1'b0, 1'b0);
		settle();
		e[3:2] = A;
		lamps_are(e);
	endtask
	task automatic t_switch;
		u_dbai_station_model.drive(5'h00, 5'h00, 2'h3, 1'b1, 1'b0);
		repeat (14) @(posedge mclk_in);
		u_dbai_station_model.drive(5'h00, 5'h00, 2'h3, 1'b0, 1'b0);
		settle();
		lamps_are(all(G));
	endtask
	task automatic t_port;
		logic [31:0] q;
		u_dbai_station_model.drive(5'h00, 5'h00, 2'h3, 1'b0, 1'b1);
		settle();
		chk_bit(rear, 1'b0);
		bus(1'b0, `DBAI_REG_INPUTS, 4'hF, 32'h0, q);
		chk_bit(q[`DBAI_IN_FRONT_BIT], 1'b1);
		chk_word(q, 32'h0000_1C00);
		u_dbai_station_model.drive(5'h00, 5'h00, 2'h3, 1'b0, 1'b0);
		settle();
		chk_bit(rear, 1'b1);
	endtask
	task automatic t_valid;
		logic [31:0] q, e;
		e = all(O);
		e[9:0] = {5{G}};
		u_dbai_station_model.drive(5'h00, 5'h00, 2'h1, 1'b0, 1'b0);
		settle();
		lamps_are(e);
		// Base 2 reports again but is masked from monitoring
		u_dbai_station_model.drive(5'h00, 5'h00, 2'h3, 1'b0, 1'b0);
		bus(1'b1, `DBAI_REG_CTRL, 4'hF, 32'h1, q);
		settle();
		lamps_are(e);
		bus(1'b0, `DBAI_REG_CTRL, 4'hF, 32'h0, q);
		chk_word(q, 32'h1);
		bus(1'b1, `DBAI_REG_CTRL, 4'hF, 32'h3, q);
		settle();
		lamps_are(all(G));
	endtask
	initial begin
		repeat (2) @(posedge mclk_in);
		nrst_in <= 1'b1;
		t_reset();
		t_alarm();
		t_clear();
		t_switch();
		t_port();
		t_valid();
		final_report();
	end
endmodule
